/* File: adcs_analog_model.sv */
// adcs_analog_model: behavioural analog core answering the trial codes
`timescale 1ns/1ns
`default_nettype none
module adcs_analog_model
  import adcs_pkg::*;
(
  // clock
  input  wire logic        clk,
  // input level chosen by the bench
  input  wire logic [11:0] level,
  // control from the sequencer
  input  wire logic        adc_power,
  input  wire logic        sample_en,
  input  wire logic [11:0] dac_code,
  // comparator answer
  output logic             comp_in
);
  logic [11:0] held;         // charge kept on the sampling capacitor
  logic        junk = 1'b0;  // toggles so an unpowered core shows no level

  // capacitor follows the input only while powered and sampling
  always_ff @(posedge clk)
  begin
    junk <= ~junk;
    if (sample_en && adc_power)
      held <= level;
  end

  // an unpowered comparator gives garbage, never a usable answer
  always_comb
  begin
    if (adc_power)
      comp_in = (held >= dac_code);
    else
      comp_in = junk;
  end
endmodule
`default_nettype wire

/* File: adcs_clk_div.sv */
// adcs_clk_div: divides the system clock into conversion clock ticks
`timescale 1ns/1ns
`default_nettype none
module adcs_clk_div
  import adcs_pkg::*;
(
  // clock and reset
  input  wire logic  clk,
  input  wire logic  rst,
  // divider link to the sequencer
  adcs_tick_if.gen   tk
);

  // ----------------------------------------------------------------
  // divide counter
  // ----------------------------------------------------------------
  logic [6:0] cnt;        // cycles since the last tick
  logic [6:0] next_cnt;   // next counter value
  logic [6:0] limit;      // terminal count, ratio minus one

  // ratio is a power of two: 1, 2, 4 ... 128 for codes 0 to 7
  assign limit   = 7'((8'h01 << tk.div_sel) - 8'h01);
  assign tk.tick = tk.run && (cnt == limit);

  // next count: held at zero when idle so every conversion starts aligned
  always_comb
  begin
    if (!tk.run || tk.tick)
      next_cnt = 7'h00;
    else
      next_cnt = cnt + 7'h01;
  end

  // register the counter
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      cnt <= 7'h00;
    else
      cnt <= next_cnt;
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  logic       seen_tick;  // a tick occurred during this run
  logic [7:0] gap;        // cycles since the previous tick

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      seen_tick <= 1'b0;
      gap       <= 8'h00;
    end
    else
    begin
      seen_tick <= tk.run && (seen_tick || tk.tick);
      gap       <= tk.tick ? 8'h00 : gap + 8'h01;
    end
  end

  chk_tick_spacing: assert property (
    @(posedge clk) disable iff (rst)
    (tk.tick && seen_tick && $stable(tk.div_sel))
      |-> (gap == ((8'h01 << tk.div_sel) - 8'h01)))
    else $error("conversion tick spacing differs from divide ratio");

endmodule
`default_nettype wire

/* File: adcs_pkg.sv */
// adcs_pkg: constants, register map and types of the conversion sequencer
package adcs_pkg;

  // ----------------------------------------------------------------
  // register map (byte offsets on the plain register port)
  // ----------------------------------------------------------------
  localparam logic [2:0] ADCS_OFF_CONTROL_0 = 3'h0;
  localparam logic [2:0] ADCS_OFF_CONTROL_1 = 3'h1;
  localparam logic [2:0] ADCS_OFF_RESULT_HI = 3'h2;
  localparam logic [2:0] ADCS_OFF_RESULT_LO = 3'h3;
  localparam logic [2:0] ADCS_OFF_IRQ       = 3'h4;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int ADCS_BIT_START   = 7;  // control_0: start request
  localparam int ADCS_BIT_BUSY    = 6;  // control_0: conv_busy_flag
  localparam int ADCS_BIT_POWER   = 5;  // control_0: adc_power_enable
  localparam int ADCS_BIT_RANGE   = 7;  // control_1: period out of range
  localparam int ADCS_BIT_IRQ_FLG = 0;  // irq: request flag, write 1 clears
  localparam int ADCS_BIT_IRQ_EN  = 1;  // irq: enable

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [2:0]  ADCS_RST_DIV_SEL = 3'h0;
  localparam logic [11:0] ADCS_RST_RESULT  = 12'h000;
  localparam logic [11:0] ADCS_SAR_MSB     = 12'h800;
  localparam logic [11:0] ADCS_FULL_SCALE  = 12'hFFF;

  // ----------------------------------------------------------------
  // timing: conversion clock periods
  // ----------------------------------------------------------------
  localparam int ADCS_SYS_PERIOD_NS = 20;
  localparam int ADCS_CONV_PER_MIN_NS = 500;
  localparam int ADCS_CONV_PER_MAX_NS = 10000;
  // least period rounds up, longest rounds down
  localparam int ADCS_CONV_MIN_CYC =
    (ADCS_CONV_PER_MIN_NS + ADCS_SYS_PERIOD_NS - 1) / ADCS_SYS_PERIOD_NS;
  localparam int ADCS_CONV_MAX_CYC =
    ADCS_CONV_PER_MAX_NS / ADCS_SYS_PERIOD_NS;
  localparam logic [1:0] ADCS_SAMPLE_LAST = 2'h3;  // 4 sampling ticks
  localparam logic [3:0] ADCS_TOTAL_LAST  = 4'hF;  // 16 ticks in all

  // ----------------------------------------------------------------
  // sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ADCS_IDLE    = 2'b00,
    ADCS_SAMPLE  = 2'b01,
    ADCS_CONVERT = 2'b10
  } adcs_state_t;

endpackage

/* File: adcs_sequencer.sv */
// adcs_sequencer: control and sequencing of the 12-bit converter
//
// Functional notes
// - start on a low-high-low start bit pulse
// - busy flag set once conversion starts
// - busy flag cleared when conversion completes
// - completion sets request flag, interrupt if enabled
// - three-bit select divides clock by 1 to 128
// - converter unpowered while power enable low
// - four sampling then twelve conversion clocks
// - twelve-bit result, full scale FFF
// - result readable from high and low registers
//
// Added by the designer: strobed register access and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
module adcs_sequencer
  import adcs_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // register port
  input  wire logic [2:0]  addr,
  input  wire logic [7:0]  wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic      [7:0]  rdata,
  // analog core
  input  wire logic        comp_in,     // comparator: input at or above trial
  output logic             adc_power,   // powers the analog core
  output logic             sample_en,   // sample switch closed
  output logic      [11:0] dac_code,    // trial code for the comparator
  // interrupt request
  output logic             irq
);

  // ----------------------------------------------------------------
  // registers and state
  // ----------------------------------------------------------------
  adcs_state_t state;           // sequencer state
  adcs_state_t next_state;
  logic        start_bit;       // stored start request bit
  logic        power_en;        // adc_power_enable
  logic [2:0]  div_sel;         // conv_clock_div_select
  logic [11:0] result;          // last completed result
  logic        irq_flag;        // sticky completion flag
  logic        irq_en;          // interrupt enable
  logic [1:0]  sample_cnt;      // sampling ticks seen
  logic [11:0] trial;           // successive approximation trial code
  logic [11:0] mask;            // bit under test, one-hot
  logic [7:0]  next_rdata;
  logic        next_start_bit;
  logic        next_power_en;
  logic [2:0]  next_div_sel;
  logic [11:0] next_result;
  logic        next_irq_flag;
  logic        next_irq_en;
  logic [1:0]  next_sample_cnt;
  logic [11:0] next_trial;
  logic [11:0] next_mask;
  logic        comp_s1;         // comparator synchroniser stages
  logic        comp_s2;

  // decoded strobes
  logic        wr_ctl0;         // write to control_0
  logic        start_pulse;     // accepted start request
  logic        done;            // last conversion tick
  logic        busy;            // conv_busy_flag
  logic        range_bad;       // divided period outside 0.5 to 10 us
  logic [11:0] decided;         // trial after the current bit decision

  adcs_tick_if tk ();

  // ----------------------------------------------------------------
  // conversion clock divider
  // ----------------------------------------------------------------
  assign tk.run     = (state != ADCS_IDLE);
  assign tk.div_sel = div_sel;

  adcs_clk_div u_div (
    .clk (clk),
    .rst (rst),
    .tk  (tk)
  );

  // ----------------------------------------------------------------
  // comparator synchroniser: the analog core is asynchronous
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      comp_s1 <= 1'b0;
      comp_s2 <= 1'b0;
    end
    else
    begin
      comp_s1 <= comp_in;
      comp_s2 <= comp_s1;
    end
  end

  // ----------------------------------------------------------------
  // control decode
  // ----------------------------------------------------------------
  assign wr_ctl0 = wr && (addr == ADCS_OFF_CONTROL_0);
  // falling edge of a start bit previously written high; ignored when
  // unpowered or already busy, since the core cannot take it then; the
  // same write must keep power on, or the run would abort a cycle later
  assign start_pulse = wr_ctl0 && start_bit && !wdata[ADCS_BIT_START]
                       && wdata[ADCS_BIT_POWER] && power_en
                       && (state == ADCS_IDLE);
  assign busy      = (state != ADCS_IDLE);
  assign done      = (state == ADCS_CONVERT) && tk.tick && mask[0];
  assign decided   = comp_s2 ? trial : (trial & ~mask);
  assign range_bad = ((9'h001 << div_sel) < 9'(ADCS_CONV_MIN_CYC)) ||
                     ((9'h001 << div_sel) > 9'(ADCS_CONV_MAX_CYC));

  // ----------------------------------------------------------------
  // sequencer: sample, then approximate one bit per tick
  // ----------------------------------------------------------------
  always_comb
  begin
    next_state      = state;
    next_sample_cnt = sample_cnt;
    next_trial      = trial;
    next_mask       = mask;
    next_result     = result;
    unique case (state)
      ADCS_IDLE:
      begin
        if (start_pulse)
        begin
          next_state      = ADCS_SAMPLE;
          next_sample_cnt = 2'h0;
        end
      end
      ADCS_SAMPLE:
      begin
        if (tk.tick)
        begin
          next_sample_cnt = sample_cnt + 2'h1;
          if (sample_cnt == ADCS_SAMPLE_LAST)
          begin
            next_state = ADCS_CONVERT;
            next_trial = ADCS_SAR_MSB;
            next_mask  = ADCS_SAR_MSB;
          end
        end
      end
      ADCS_CONVERT:
      begin
        if (tk.tick)
        begin
          // keep the bit if the input sits at or above the trial level
          next_trial = decided | (mask >> 1);
          next_mask  = mask >> 1;
          if (mask[0])
          begin
            next_result = decided;
            next_state  = ADCS_IDLE;
          end
        end
      end
      default:
      begin
        next_state = ADCS_IDLE;
      end
    endcase
    // dropping power aborts any conversion in flight
    if (!power_en)
      next_state = ADCS_IDLE;
  end

  // ----------------------------------------------------------------
  // register file: next values
  // ----------------------------------------------------------------
  always_comb
  begin
    next_start_bit = start_bit;
    next_power_en  = power_en;
    next_div_sel   = div_sel;
    next_irq_en    = irq_en;
    next_irq_flag  = irq_flag;
    if (wr_ctl0)
    begin
      next_start_bit = wdata[ADCS_BIT_START];
      next_power_en  = wdata[ADCS_BIT_POWER];
    end
    if (wr && (addr == ADCS_OFF_CONTROL_1))
      next_div_sel = wdata[2:0];
    if (wr && (addr == ADCS_OFF_IRQ))
    begin
      next_irq_en = wdata[ADCS_BIT_IRQ_EN];
      if (wdata[ADCS_BIT_IRQ_FLG])
        next_irq_flag = 1'b0;
    end
    // completion after the clear so an event in the same cycle survives
    if (done)
      next_irq_flag = 1'b1;
    // read data for the cycle after the strobe
    next_rdata = 8'h00;
    if (rd)
    begin
      unique case (addr)
        ADCS_OFF_CONTROL_0:
          next_rdata = {start_bit, busy, power_en, 5'h00};
        ADCS_OFF_CONTROL_1:
          next_rdata = {range_bad, 4'h0, div_sel};
        ADCS_OFF_RESULT_HI:
          next_rdata = {4'h0, result[11:8]};
        ADCS_OFF_RESULT_LO:
          next_rdata = result[7:0];
        ADCS_OFF_IRQ:
          next_rdata = {6'h00, irq_en, irq_flag};
        default:
          next_rdata = 8'h00;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // register all state
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      state      <= ADCS_IDLE;
      start_bit  <= 1'b0;
      power_en   <= 1'b0;
      div_sel    <= ADCS_RST_DIV_SEL;
      result     <= ADCS_RST_RESULT;
      irq_flag   <= 1'b0;
      irq_en     <= 1'b0;
      sample_cnt <= 2'h0;
      trial      <= ADCS_RST_RESULT;
      mask       <= ADCS_RST_RESULT;
      rdata      <= 8'h00;
    end
    else
    begin
      state      <= next_state;
      start_bit  <= next_start_bit;
      power_en   <= next_power_en;
      div_sel    <= next_div_sel;
      result     <= next_result;
      irq_flag   <= next_irq_flag;
      irq_en     <= next_irq_en;
      sample_cnt <= next_sample_cnt;
      trial      <= next_trial;
      mask       <= next_mask;
      rdata      <= next_rdata;
    end
  end

  // ----------------------------------------------------------------
  // outputs to the analog core and interrupt controller
  // ----------------------------------------------------------------
  // note: the comparator is read through two flops, so a divide of 1 or 2
  // decides each bit on an earlier trial's answer; such periods are too short anyway
  assign adc_power = power_en;
  assign sample_en = (state == ADCS_SAMPLE);
  assign dac_code  = trial;
  assign irq       = irq_flag && irq_en;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  logic [3:0] tick_cnt;   // conversion ticks since start

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      tick_cnt <= 4'h0;
    else if (start_pulse)
      tick_cnt <= 4'h0;
    else if (busy && tk.tick)
      tick_cnt <= tick_cnt + 4'h1;
  end

  chk_start_sets_busy: assert property (
    @(posedge clk) disable iff (rst)
    start_pulse |=> busy && sample_en)
    else $error("busy not set after start request");

  chk_busy_clears: assert property (
    @(posedge clk) disable iff (rst)
    done |=> !busy)
    else $error("busy did not clear after completion");

  chk_flag_on_done: assert property (
    @(posedge clk) disable iff (rst)
    done |=> irq_flag ##0 (irq == irq_en))
    else $error("completion flag or interrupt missing");

  chk_sixteen_ticks: assert property (
    @(posedge clk) disable iff (rst)
    done |-> (tick_cnt == ADCS_TOTAL_LAST))
    else $error("conversion did not take sixteen clocks");

  chk_sample_phase: assert property (
    @(posedge clk) disable iff (rst)
    (sample_en && tk.tick && sample_cnt == ADCS_SAMPLE_LAST && power_en)
      |=> (state == ADCS_CONVERT) && (dac_code == ADCS_SAR_MSB))
    else $error("sampling phase length wrong");

  chk_power_gate: assert property (
    @(posedge clk) disable iff (rst)
    !adc_power |=> !busy)
    else $error("conversion running while unpowered");

  chk_result_fresh: assert property (
    @(posedge clk) disable iff (rst)
    done |=> (result == $past(decided)))
    else $error("result not stored with busy clear");

  chk_read_result: assert property (
    @(posedge clk) disable iff (rst)
    (rd && addr == ADCS_OFF_RESULT_LO) |=> (rdata == $past(result[7:0])))
    else $error("low result read back wrong");

  chk_idle_no_start: assert property (
    @(posedge clk) disable iff (rst)
    (!busy && !start_pulse) |=> !busy)
    else $error("conversion began without a start pulse");

endmodule
`default_nettype wire

/* File: adcs_tick_if.sv */
// adcs_tick_if: carries divider control and the conversion clock tick
`timescale 1ns/1ns
`default_nettype none
interface adcs_tick_if;
  logic       run;      // divider counts while high, held at zero otherwise
  logic [2:0] div_sel;  // conv_clock_div_select
  logic       tick;     // one-cycle pulse per conversion clock period

  modport ctrl (output run, output div_sel, input tick);
  modport gen  (input run, input div_sel, output tick);
endinterface
`default_nettype wire

/* File: tb_adc_conversion_sequencer.sv */
// tb_adc_conversion_sequencer: self-checking bench of the sequencer
`timescale 1ns/1ns
`default_nettype none
module tb_adc_conversion_sequencer
  import adcs_pkg::*;
;
  localparam int SETTLE = 16;  // power-up wait before any start

  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic        clk;
  logic        rst;
  logic [2:0]  addr;
  logic [7:0]  wdata;
  logic        wr;
  logic        rd;
  logic [7:0]  rdata;
  logic        comp_in;
  logic        adc_power;
  logic        sample_en;
  logic [11:0] dac_code;
  logic        irq;
  logic [11:0] level;
  int          failures;
  int          n_checks;

  adcs_sequencer uut (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .comp_in(comp_in),
    .adc_power(adc_power), .sample_en(sample_en), .dac_code(dac_code),
    .irq(irq));

  adcs_analog_model core (.clk(clk), .level(level), .adc_power(adc_power),
    .sample_en(sample_en), .dac_code(dac_code), .comp_in(comp_in));

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  always #10 clk = ~clk;

  task automatic check(input string what, input logic [11:0] exp,
                       input logic [11:0] got);
    n_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wrap_up;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // one write strobe, released at the next edge
  task automatic bus_write(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  // one read strobe; data taken in the following cycle only
  task automatic bus_read(input logic [2:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    d = rdata;
  endtask

  task automatic read_check(input string what, input logic [2:0] a,
                            input logic [7:0] exp);
    logic [7:0] d;
    bus_read(a, d);
    check(what, 12'(exp), 12'(d));
  endtask

  // start pulse, then poll busy every cycle until it drops
  task automatic run_conv(input logic [11:0] val, output int samp,
                          output int busy);
    int guard;
    samp  = 0;
    busy  = 0;
    guard = 0;
    level <= val;
    bus_write(ADCS_OFF_CONTROL_0, 8'hA0);
    bus_write(ADCS_OFF_CONTROL_0, 8'h20);
    addr <= ADCS_OFF_CONTROL_0;
    rd   <= 1'b1;
    do
    begin
      @(negedge clk);
      if (sample_en === 1'b1)
        samp++;
      if (rdata[ADCS_BIT_BUSY] === 1'b1)
        busy++;
      guard++;
    end while ((busy == 0 || rdata[ADCS_BIT_BUSY] === 1'b1) && guard < 5000);
    @(posedge clk);
    rd <= 1'b0;
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    check("power after reset", 12'h000, 12'(adc_power));
    read_check("control_0 reset", ADCS_OFF_CONTROL_0, 8'h00);
    read_check("control_1 reset", ADCS_OFF_CONTROL_1, 8'h80);
    read_check("result_high reset", ADCS_OFF_RESULT_HI, 8'h00);
    read_check("result_low reset", ADCS_OFF_RESULT_LO, 8'h00);
    read_check("irq reset", ADCS_OFF_IRQ, 8'h00);
    read_check("unmapped read", 3'h5, 8'h00);
  endtask

  // every divider code: 4 and 16 conversion clocks of 2^code cycles
  task automatic t_divider;
    int samp;
    int busy;
    bus_write(ADCS_OFF_CONTROL_0, 8'h20);
    // the write lands on the edge bus_write returns at; look once settled
    @(negedge clk);
    check("power on", 12'h001, 12'(adc_power));
    repeat (SETTLE) @(posedge clk);
    for (int c = 0; c < 8; c++)
    begin
      bus_write(ADCS_OFF_CONTROL_1, 8'(c));
      read_check("div select", ADCS_OFF_CONTROL_1,
                 {(c < 5), 4'h0, 3'(c)});
      run_conv(12'h5A5, samp, busy);
      check("sample cycles", 12'(4 << c), 12'(samp));
      check("busy cycles", 12'(16 << c), 12'(busy));
      bus_write(ADCS_OFF_IRQ, 8'h01);
    end
  endtask

  // codes read back whole right after busy clears; ratio 4 lets the
  // comparator's synchroniser settle within each trial
  task automatic t_results;
    logic [11:0] vals [6] = '{12'h000, 12'hFFF, 12'h800, 12'h7FF,
                              12'hA5A, 12'h001};
    int samp;
    int busy;
    bus_write(ADCS_OFF_CONTROL_1, 8'h02);
    foreach (vals[i])
    begin
      run_conv(vals[i], samp, busy);
      read_check("result_high", ADCS_OFF_RESULT_HI,
                 {4'h0, vals[i][11:8]});
      read_check("result_low", ADCS_OFF_RESULT_LO, vals[i][7:0]);
      read_check("flag set", ADCS_OFF_IRQ, 8'h01);
      check("irq masked", 12'h000, 12'(irq));
      bus_write(ADCS_OFF_IRQ, 8'h01);
    end
  endtask

  task automatic t_irq;
    int samp;
    int busy;
    bus_write(ADCS_OFF_IRQ, 8'h02);
    run_conv(12'h123, samp, busy);
    @(negedge clk);
    check("irq raised", 12'h001, 12'(irq));
    read_check("flag and enable", ADCS_OFF_IRQ, 8'h03);
    bus_write(ADCS_OFF_IRQ, 8'h03);
    @(negedge clk);
    check("irq cleared", 12'h000, 12'(irq));
    bus_write(ADCS_OFF_IRQ, 8'h00);
  endtask

  // starts while unpowered are dropped; power loss aborts a conversion
  task automatic t_power;
    int seen;
    seen = 0;
    bus_write(ADCS_OFF_CONTROL_0, 8'h80);
    bus_write(ADCS_OFF_CONTROL_0, 8'h00);
    repeat (20)
    begin
      @(negedge clk);
      seen += int'(sample_en === 1'b1);
    end
    check("unpowered start", 12'h000, 12'(seen));
    read_check("unpowered busy", ADCS_OFF_CONTROL_0, 8'h00);
    bus_write(ADCS_OFF_CONTROL_1, 8'h07);
    bus_write(ADCS_OFF_CONTROL_0, 8'h20);
    repeat (SETTLE) @(posedge clk);
    level <= 12'hF0F;
    bus_write(ADCS_OFF_CONTROL_0, 8'hA0);
    bus_write(ADCS_OFF_CONTROL_0, 8'h20);
    repeat (100) @(posedge clk);
    read_check("busy mid run", ADCS_OFF_CONTROL_0, 8'h60);
    bus_write(ADCS_OFF_CONTROL_0, 8'h00);
    read_check("aborted busy", ADCS_OFF_CONTROL_0, 8'h00);
    check("power off", 12'h000, 12'(adc_power));
    read_check("no flag", ADCS_OFF_IRQ, 8'h00);
    read_check("result kept", ADCS_OFF_RESULT_LO, 8'h23);
  endtask

  // ----------------------------------------------------------------
  // main sequence and watchdog
  // ----------------------------------------------------------------
  initial
  begin
    clk      = 1'b0;
    rst      = 1'b1;
    addr     = 3'h0;
    wdata    = 8'h00;
    wr       = 1'b0;
    rd       = 1'b0;
    level    = 12'h000;
    failures = 0;
    n_checks = 0;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    t_reset();
    t_divider();
    t_results();
    t_irq();
    t_power();
    wrap_up();
  end

  // conversions need about 5000 cycles; far more means a hang
  initial
  begin
    repeat (40000) @(posedge clk);
    failures++;
    wrap_up();
  end
endmodule
`default_nettype wire
